// File: cpu_addr_defs.svh
// constant definitions for the cpu addressing and decode block
`ifndef CPU_ADDR_DEFS_SVH
`define CPU_ADDR_DEFS_SVH

// reset values and the zero page high address byte
`define RESET_PC_VAL 16'h0000
`define STACK_TOP_VAL 8'hFF
`define CCR_RESET_VAL 5'h08
`define ZERO_PAGE_HI 8'h00

// condition code bit positions
`define CCR_C 0
`define CCR_Z 1
`define CCR_N 2
`define CCR_I 3
`define CCR_H 4

// opcode upper nibble selects the addressing mode column
`define HI_BIT_BRANCH 4'h0
`define HI_BIT_SETCLR 4'h1
`define HI_RELATIVE 4'h2
`define HI_DIRECT_RMW 4'h3
`define HI_INH_ACC 4'h4
`define HI_INH_IDX 4'h5
`define HI_IX1_RMW 4'h6
`define HI_IX_RMW 4'h7
`define HI_IMMEDIATE 4'hA
`define HI_DIRECT 4'hB
`define HI_EXTENDED 4'hC
`define HI_IX2 4'hD
`define HI_IX1 4'hE
`define HI_IX 4'hF

// read-modify-write operations, lower nibble
`define RMW_NEGATE 4'h0
`define RMW_COMPLEMENT 4'h3
`define RMW_SHIFT_RIGHT 4'h4
`define RMW_SHIFT_LEFT 4'h8
`define RMW_DECREMENT 4'hA
`define RMW_INCREMENT 4'hC
`define RMW_TEST_NEGATIVE_ZERO 4'hD
`define RMW_CLEAR 4'hF

// register/memory operations, lower nibble
`define RM_SUBTRACT 4'h0
`define RM_COMPARE 4'h1
`define RM_COMPARE_INDEX 4'h3
`define RM_AND 4'h4
`define RM_LOAD_ACC 4'h6
`define RM_STORE_ACC 4'h7
`define RM_XOR 4'h8
`define RM_OR 4'hA
`define RM_ADD 4'hB
`define RM_UNCONDITIONAL_JUMP 4'hC
`define RM_JUMP_SUBROUTINE 4'hD
`define RM_LOAD_INDEX 4'hE
`define RM_STORE_INDEX 4'hF

// relative branch conditions, lower nibble
`define BR_ALWAYS 4'h0
`define BR_NEVER 4'h1
`define BR_HIGHER 4'h2
`define BR_LOWER_SAME 4'h3
`define BR_CARRY_CLEAR 4'h4
`define BR_CARRY_SET 4'h5
`define BR_NOT_EQUAL 4'h6
`define BR_EQUAL 4'h7
`define BR_HALF_CLEAR 4'h8
`define BR_HALF_SET 4'h9
`define BR_PLUS 4'hA
`define BR_MINUS 4'hB
`define BR_MASK_CLEAR 4'hC
`define BR_MASK_SET 4'hD
`define BR_IRQ_PIN_LOW 4'hE
`define BR_IRQ_PIN_HIGH 4'hF

// whole inherent opcodes
`define OPC_UNSIGNED_MULTIPLY 8'h42
`define OPC_ACC_TO_IDX 8'h97
`define OPC_CARRY_CLEAR 8'h98
`define OPC_CARRY_SET 8'h99
`define OPC_IDX_TO_ACC 8'h9F

`endif

// File: cpu_addr_pkg.sv
// types shared by the cpu addressing and decode block
package cpu_addr_pkg;

	// sequencer states, gray coded in declaration order
	typedef enum logic [3:0] {
		S_FETCH = 4'h0,
		S_WAIT = 4'h1,
		S_DECODE = 4'h3,
		S_OP1 = 4'h2,
		S_OP2 = 4'h6,
		S_EA = 4'h7,
		S_DATA = 4'h5,
		S_BREL = 4'h4,
		S_PUSHL = 4'hC,
		S_PUSHH = 4'hD
	} seq_state_t;

	// addressing mode of an opcode
	typedef enum logic [3:0] {
		M_INH = 4'h0,
		M_IMM = 4'h1,
		M_DIR = 4'h2,
		M_EXT = 4'h3,
		M_IX = 4'h4,
		M_IX1 = 4'h5,
		M_IX2 = 4'h6,
		M_REL = 4'h7,
		M_BIT_BRANCH = 4'h8,
		M_BIT_SETCLR = 4'h9
	} addr_mode_t;

endpackage : cpu_addr_pkg

// File: unsigned_multiply_unit.sv
// unsigned 8 by 8 multiplier returning the product halves
module unsigned_multiply_unit (
	input wire logic [7:0] acc_in, // accumulator operand
	input wire logic [7:0] idx_in, // index register operand
	output logic [7:0] hi_out, // upper product byte
	output logic [7:0] lo_out // lower product byte
);

	logic [15:0] product;

	// full-width product so no bit is lost before the split
	assign product = {8'h00, acc_in} * {8'h00, idx_in};
	assign hi_out = product[15:8];
	assign lo_out = product[7:0];

endmodule : unsigned_multiply_unit

// File: cpu_addressing_decode.sv
// instruction fetch, addressing mode and execute sequencer of the 8-bit cpu
// Behaviour
// - multiply puts product high byte in index register, low byte in accumulator
// - inherent instructions are one opcode byte with no operand
// - immediate instructions are two bytes, literal used with accumulator or index
// - direct uses second byte as low address, high address byte zero
// - extended is three bytes, high then low address byte
// - indexed no offset is one byte, address is index with zero high
// - indexed 8-bit offset adds index and offset byte unsigned
// - indexed 16-bit offset takes high then low offset byte plus index
// - relative addressing only for branch instructions
// - taken branch adds sign-extended offset to next instruction address
// - false branch condition continues with the next instruction
// - read-modify-write reads, alters and writes back to the same place
// - single bit set and clear decode only with direct addressing
// - test negative or zero updates flags without write-back
// - bit test branch is opcode, direct address, signed offset
// - bit test branch reads any bit of first 256 locations
// - bit test branch copies tested bit into carry
// - register/memory takes one operand from register, other from memory
// - branches on external interrupt pin high and pin low
// - jump and jump to subroutine load program counter with effective address
`include "cpu_addr_defs.svh"

module cpu_addressing_decode
	import cpu_addr_pkg::*;
#(
	parameter logic [15:0] RESET_PC = `RESET_PC_VAL,
	parameter logic [7:0] STACK_TOP = `STACK_TOP_VAL
) (
	input wire logic clk_in, // cpu clock
	input wire logic resetn_in, // synchronous reset, active low
	input wire logic [7:0] mem_rdata_in, // read data, one cycle after the read strobe
	input wire logic irq_pin_in, // external interrupt request pin level
	output logic [15:0] mem_addr_out, // memory address
	output logic mem_rd_out, // memory read strobe
	output logic mem_wr_out, // memory write strobe
	output logic [7:0] mem_wdata_out, // memory write data
	output logic [7:0] acc_out, // accumulator
	output logic [7:0] idx_out, // index register
	output logic [15:0] pc_out, // program counter
	output logic [4:0] ccr_out, // condition codes h i n z c
	output logic done_out // pulse when an instruction completes
);

	// refuse a stack that cannot hold one return address
	if (STACK_TOP < 8'h02) begin : g_stack_check
		$error("stack top too low for a return address");
	end

	// addressing mode from the opcode column
	function automatic addr_mode_t op_mode(input logic [7:0] op);
		case (op[7:4])
			`HI_BIT_BRANCH: return M_BIT_BRANCH;
			`HI_BIT_SETCLR: return M_BIT_SETCLR;
			`HI_RELATIVE: return M_REL;
			`HI_DIRECT_RMW, `HI_DIRECT: return M_DIR;
			`HI_IX1_RMW, `HI_IX1: return M_IX1;
			`HI_IX_RMW, `HI_IX: return M_IX;
			`HI_IMMEDIATE: return M_IMM;
			`HI_EXTENDED: return M_EXT;
			`HI_IX2: return M_IX2;
			default: return M_INH;
		endcase
	endfunction : op_mode

	// read-modify-write arithmetic: returns {write back, carry, result}
	function automatic logic [9:0] rmw_calc(input logic [3:0] lo, input logic [7:0] v, input logic c);
		logic [7:0] r;
		logic nc;
		logic wb;
		r = v;
		nc = c;
		wb = 1'b1;
		case (lo)
			`RMW_NEGATE: begin r = 8'h00 - v; nc = (r != 8'h00); end
			`RMW_COMPLEMENT: begin r = ~v; nc = 1'b1; end
			`RMW_SHIFT_RIGHT: begin r = {1'b0, v[7:1]}; nc = v[0]; end
			`RMW_SHIFT_LEFT: begin r = {v[6:0], 1'b0}; nc = v[7]; end
			`RMW_DECREMENT: r = v - 8'h01;
			`RMW_INCREMENT: r = v + 8'h01;
			`RMW_TEST_NEGATIVE_ZERO: wb = 1'b0;
			`RMW_CLEAR: r = 8'h00;
			default: wb = 1'b1;
		endcase
		return {wb, nc, r};
	endfunction : rmw_calc

	// register/memory operation on a register and a memory byte: {acc, idx, ccr}
	function automatic logic [20:0] regmem_exec(input logic [3:0] lo, input logic [7:0] a, input logic [7:0] x,
			input logic [7:0] v, input logic [4:0] cc);
		logic [8:0] t;
		logic [7:0] na;
		logic [7:0] nx;
		logic [7:0] r;
		logic [4:0] nc;
		na = a;
		nx = x;
		nc = cc;
		t = 9'h000;
		r = a;
		case (lo)
			`RM_SUBTRACT: begin t = {1'b0, a} - {1'b0, v}; na = t[7:0]; r = na; nc[`CCR_C] = t[8]; end
			`RM_COMPARE: begin t = {1'b0, a} - {1'b0, v}; r = t[7:0]; nc[`CCR_C] = t[8]; end
			`RM_COMPARE_INDEX: begin t = {1'b0, x} - {1'b0, v}; r = t[7:0]; nc[`CCR_C] = t[8]; end
			`RM_AND: begin na = a & v; r = na; end
			`RM_LOAD_ACC: begin na = v; r = v; end
			`RM_XOR: begin na = a ^ v; r = na; end
			`RM_OR: begin na = a | v; r = na; end
			`RM_ADD: begin
				t = {1'b0, a} + {1'b0, v};
				na = t[7:0];
				r = na;
				nc[`CCR_C] = t[8];
				nc[`CCR_H] = a[4] ^ v[4] ^ t[4];
			end
			`RM_LOAD_INDEX: begin nx = v; r = v; end
			default: r = a;
		endcase
		nc[`CCR_N] = r[7];
		nc[`CCR_Z] = (r == 8'h00);
		return {na, nx, nc};
	endfunction : regmem_exec

	seq_state_t state_ff, nxt_state, ret_ff, nxt_ret;
	logic [15:0] pc_ff, nxt_pc, ea_ff, nxt_ea, addr_ff, nxt_addr;
	logic [7:0] acc_ff, nxt_acc, idx_ff, nxt_idx, sp_ff, nxt_sp, op_ff, nxt_op, b1_ff, nxt_b1, wdata_ff, nxt_wdata;
	logic [4:0] ccr_ff, nxt_ccr;
	logic rd_ff, nxt_rd, wr_ff, nxt_wr, taken_ff, nxt_taken, done_ff, irq_meta_ff, irq_sync_ff;

	// decode views of the opcode being decoded and the latched opcode
	addr_mode_t dec_mode, cur_mode;
	logic [3:0] cur_lo;
	logic is_rmw, is_store, is_jump, is_call, bit_val, br_true;
	logic [7:0] bit_mask, rmw_src, mul_hi, mul_lo;
	logic [9:0] rmw_res;
	logic [20:0] rm_res;
	logic [15:0] rel_off;
	assign dec_mode = op_mode(mem_rdata_in);
	assign cur_mode = op_mode(op_ff);
	assign cur_lo = op_ff[3:0];
	assign is_rmw = (op_ff[7:4] == `HI_DIRECT_RMW) || (op_ff[7:4] == `HI_IX1_RMW) || (op_ff[7:4] == `HI_IX_RMW);
	assign is_store = (cur_lo == `RM_STORE_ACC) || (cur_lo == `RM_STORE_INDEX);
	assign is_jump = (cur_lo == `RM_UNCONDITIONAL_JUMP);
	assign is_call = (cur_lo == `RM_JUMP_SUBROUTINE);
	assign bit_mask = 8'h01 << op_ff[3:1];
	assign bit_val = |(mem_rdata_in & bit_mask);
	assign rel_off = {{8{mem_rdata_in[7]}}, mem_rdata_in};
	// inherent forms work on a or x, memory forms on the byte just read
	assign rmw_src = (state_ff == S_DECODE) ? (mem_rdata_in[4] ? idx_ff : acc_ff) : mem_rdata_in;
	assign rmw_res = rmw_calc((state_ff == S_DECODE) ? mem_rdata_in[3:0] : cur_lo, rmw_src, ccr_ff[`CCR_C]);
	assign rm_res = regmem_exec(cur_lo, acc_ff, idx_ff, mem_rdata_in, ccr_ff);

	// relative branch conditions, pin levels come through the synchroniser
	always_comb begin
		case (cur_lo)
			`BR_ALWAYS: br_true = 1'b1;
			`BR_NEVER: br_true = 1'b0;
			`BR_HIGHER: br_true = !(ccr_ff[`CCR_C] | ccr_ff[`CCR_Z]);
			`BR_LOWER_SAME: br_true = ccr_ff[`CCR_C] | ccr_ff[`CCR_Z];
			`BR_CARRY_CLEAR: br_true = !ccr_ff[`CCR_C];
			`BR_CARRY_SET: br_true = ccr_ff[`CCR_C];
			`BR_NOT_EQUAL: br_true = !ccr_ff[`CCR_Z];
			`BR_EQUAL: br_true = ccr_ff[`CCR_Z];
			`BR_HALF_CLEAR: br_true = !ccr_ff[`CCR_H];
			`BR_HALF_SET: br_true = ccr_ff[`CCR_H];
			`BR_PLUS: br_true = !ccr_ff[`CCR_N];
			`BR_MINUS: br_true = ccr_ff[`CCR_N];
			`BR_MASK_CLEAR: br_true = !ccr_ff[`CCR_I];
			`BR_MASK_SET: br_true = ccr_ff[`CCR_I];
			`BR_IRQ_PIN_LOW: br_true = !irq_sync_ff;
			`BR_IRQ_PIN_HIGH: br_true = irq_sync_ff;
			default: br_true = 1'b0;
		endcase
	end

	unsigned_multiply_unit u_mul (
		.acc_in(acc_ff),
		.idx_in(idx_ff),
		.hi_out(mul_hi),
		.lo_out(mul_lo)
	);

	// sequencer: a read issued on a transition is visible in S_WAIT, its data in the state after
	always_comb begin
		nxt_state = state_ff;
		nxt_ret = ret_ff;
		nxt_pc = pc_ff;
		nxt_ea = ea_ff;
		nxt_addr = addr_ff;
		nxt_acc = acc_ff;
		nxt_idx = idx_ff;
		nxt_sp = sp_ff;
		nxt_op = op_ff;
		nxt_b1 = b1_ff;
		nxt_wdata = wdata_ff;
		nxt_ccr = ccr_ff;
		nxt_taken = taken_ff;
		nxt_rd = 1'b0;
		nxt_wr = 1'b0;
		case (state_ff)
			S_FETCH: begin
				nxt_rd = 1'b1;
				nxt_addr = pc_ff;
				nxt_pc = pc_ff + 16'h0001;
				nxt_ret = S_DECODE;
				nxt_state = S_WAIT;
			end
			S_WAIT: nxt_state = ret_ff;
			S_DECODE: begin
				nxt_op = mem_rdata_in;
				nxt_state = S_FETCH;
				if (dec_mode == M_INH) begin
					if (mem_rdata_in == `OPC_UNSIGNED_MULTIPLY) begin
						nxt_idx = mul_hi;
						nxt_acc = mul_lo;
						nxt_ccr[`CCR_C] = 1'b0;
						nxt_ccr[`CCR_H] = 1'b0;
					end else if (mem_rdata_in[7:4] == `HI_INH_ACC || mem_rdata_in[7:4] == `HI_INH_IDX) begin
						if (rmw_res[9] && !mem_rdata_in[4]) nxt_acc = rmw_res[7:0];
						if (rmw_res[9] && mem_rdata_in[4]) nxt_idx = rmw_res[7:0];
						nxt_ccr[`CCR_C] = rmw_res[8];
						nxt_ccr[`CCR_N] = rmw_res[7];
						nxt_ccr[`CCR_Z] = (rmw_res[7:0] == 8'h00);
					end else if (mem_rdata_in == `OPC_ACC_TO_IDX) begin
						nxt_idx = acc_ff;
					end else if (mem_rdata_in == `OPC_IDX_TO_ACC) begin
						nxt_acc = idx_ff;
					end else if (mem_rdata_in == `OPC_CARRY_CLEAR || mem_rdata_in == `OPC_CARRY_SET) begin
						nxt_ccr[`CCR_C] = mem_rdata_in[0];
					end
				end else if (dec_mode == M_IX) begin
					nxt_ea = {`ZERO_PAGE_HI, idx_ff};
					nxt_state = S_EA;
				end else begin
					nxt_rd = 1'b1;
					nxt_addr = pc_ff;
					nxt_pc = pc_ff + 16'h0001;
					nxt_ret = S_OP1;
					nxt_state = S_WAIT;
				end
			end
			S_OP1: begin
				nxt_b1 = mem_rdata_in;
				nxt_state = S_EA;
				case (cur_mode)
					M_IMM: begin
						if (!is_store && !is_jump && !is_call) begin
							{nxt_acc, nxt_idx, nxt_ccr} = rm_res;
						end
						nxt_state = S_FETCH;
					end
					M_REL: begin
						if (br_true) nxt_pc = pc_ff + rel_off;
						nxt_state = S_FETCH;
					end
					M_IX1: nxt_ea = {`ZERO_PAGE_HI, idx_ff} + {`ZERO_PAGE_HI, mem_rdata_in};
					M_EXT, M_IX2: begin
						nxt_rd = 1'b1;
						nxt_addr = pc_ff;
						nxt_pc = pc_ff + 16'h0001;
						nxt_ret = S_OP2;
						nxt_state = S_WAIT;
					end
					default: nxt_ea = {`ZERO_PAGE_HI, mem_rdata_in};
				endcase
			end
			S_OP2: begin
				nxt_ea = {b1_ff, mem_rdata_in};
				if (cur_mode == M_IX2) nxt_ea = {b1_ff, mem_rdata_in} + {`ZERO_PAGE_HI, idx_ff};
				nxt_state = S_EA;
			end
			S_EA: begin
				nxt_state = S_FETCH;
				if (!is_rmw && cur_mode != M_BIT_BRANCH && cur_mode != M_BIT_SETCLR && is_jump) begin
					nxt_pc = ea_ff;
				end else if (!is_rmw && cur_mode != M_BIT_BRANCH && cur_mode != M_BIT_SETCLR && is_call) begin
					nxt_wr = 1'b1;
					nxt_addr = {`ZERO_PAGE_HI, sp_ff};
					nxt_wdata = pc_ff[7:0];
					nxt_sp = sp_ff - 8'h01;
					nxt_state = S_PUSHL;
				end else if (!is_rmw && cur_mode != M_BIT_BRANCH && cur_mode != M_BIT_SETCLR && is_store) begin
					nxt_wr = 1'b1;
					nxt_addr = ea_ff;
					nxt_wdata = cur_lo[3] ? idx_ff : acc_ff;
					nxt_ccr[`CCR_N] = nxt_wdata[7];
					nxt_ccr[`CCR_Z] = (nxt_wdata == 8'h00);
				end else begin
					nxt_rd = 1'b1;
					nxt_addr = ea_ff;
					nxt_ret = S_DATA;
					nxt_state = S_WAIT;
				end
			end
			S_DATA: begin
				nxt_state = S_FETCH;
				if (cur_mode == M_BIT_BRANCH) begin
					nxt_ccr[`CCR_C] = bit_val;
					nxt_taken = op_ff[0] ? !bit_val : bit_val;
					nxt_rd = 1'b1;
					nxt_addr = pc_ff;
					nxt_pc = pc_ff + 16'h0001;
					nxt_ret = S_BREL;
					nxt_state = S_WAIT;
				end else if (cur_mode == M_BIT_SETCLR) begin
					nxt_wr = 1'b1;
					nxt_addr = ea_ff;
					nxt_wdata = op_ff[0] ? (mem_rdata_in & ~bit_mask) : (mem_rdata_in | bit_mask);
				end else if (is_rmw) begin
					nxt_ccr[`CCR_C] = rmw_res[8];
					nxt_ccr[`CCR_N] = rmw_res[7];
					nxt_ccr[`CCR_Z] = (rmw_res[7:0] == 8'h00);
					nxt_wr = rmw_res[9];
					nxt_addr = ea_ff;
					nxt_wdata = rmw_res[7:0];
				end else begin
					{nxt_acc, nxt_idx, nxt_ccr} = rm_res;
				end
			end
			S_BREL: begin
				if (taken_ff) nxt_pc = pc_ff + rel_off;
				nxt_state = S_FETCH;
			end
			S_PUSHL: begin
				nxt_wr = 1'b1;
				nxt_addr = {`ZERO_PAGE_HI, sp_ff};
				nxt_wdata = pc_ff[15:8];
				nxt_sp = sp_ff - 8'h01;
				nxt_state = S_PUSHH;
			end
			S_PUSHH: begin
				nxt_pc = ea_ff;
				nxt_state = S_FETCH;
			end
			default: nxt_state = S_FETCH;
		endcase
	end

	// cpu registers and memory strobes
	always_ff @(posedge clk_in) begin
		if (!resetn_in) begin
			state_ff <= S_FETCH;
			ret_ff <= S_FETCH;
			pc_ff <= RESET_PC;
			ea_ff <= 16'h0000;
			addr_ff <= 16'h0000;
			acc_ff <= 8'h00;
			idx_ff <= 8'h00;
			sp_ff <= STACK_TOP;
			op_ff <= 8'h00;
			b1_ff <= 8'h00;
			wdata_ff <= 8'h00;
			ccr_ff <= `CCR_RESET_VAL;
			taken_ff <= 1'b0;
			rd_ff <= 1'b0;
			wr_ff <= 1'b0;
			done_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			ret_ff <= nxt_ret;
			pc_ff <= nxt_pc;
			ea_ff <= nxt_ea;
			addr_ff <= nxt_addr;
			acc_ff <= nxt_acc;
			idx_ff <= nxt_idx;
			sp_ff <= nxt_sp;
			op_ff <= nxt_op;
			b1_ff <= nxt_b1;
			wdata_ff <= nxt_wdata;
			ccr_ff <= nxt_ccr;
			taken_ff <= nxt_taken;
			rd_ff <= nxt_rd;
			wr_ff <= nxt_wr;
			done_ff <= (nxt_state == S_FETCH) && (state_ff != S_FETCH);
		end
	end

	// two-stage synchroniser for the interrupt pin
	always_ff @(posedge clk_in) begin
		if (!resetn_in) begin
			irq_meta_ff <= 1'b0;
			irq_sync_ff <= 1'b0;
		end else begin
			irq_meta_ff <= irq_pin_in;
			irq_sync_ff <= irq_meta_ff;
		end
	end

	assign mem_addr_out = addr_ff;
	assign mem_rd_out = rd_ff;
	assign mem_wr_out = wr_ff;
	assign mem_wdata_out = wdata_ff;
	assign acc_out = acc_ff;
	assign idx_out = idx_ff;
	assign pc_out = pc_ff;
	assign ccr_out = ccr_ff;
	assign done_out = done_ff;

	// checks
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!resetn_in);

	sequence rmw_read_s;
		state_ff == S_DATA && is_rmw && cur_lo != `RMW_TEST_NEGATIVE_ZERO;
	endsequence
	sequence ext_addr_s;
		state_ff == S_OP2 && cur_mode == M_EXT;
	endsequence

	mul_product_place_a: assert property (state_ff == S_DECODE && mem_rdata_in == `OPC_UNSIGNED_MULTIPLY
		|=> {idx_ff, acc_ff} == {8'h00, $past(acc_ff)} * {8'h00, $past(idx_ff)})
		else $error("multiply product misplaced");
	inherent_length_a: assert property (state_ff == S_DECODE && dec_mode == M_INH
		|=> state_ff == S_FETCH && pc_ff == $past(pc_ff))
		else $error("inherent instruction consumed an operand byte");
	direct_zero_page_a: assert property (state_ff == S_EA && (cur_mode == M_DIR || cur_mode == M_BIT_SETCLR)
		|-> ea_ff[15:8] == `ZERO_PAGE_HI)
		else $error("direct address outside first page");
	ext_address_a: assert property (ext_addr_s |=> state_ff == S_EA && ea_ff == {$past(b1_ff), $past(mem_rdata_in)})
		else $error("extended address bytes misordered");
	index_plain_a: assert property (state_ff == S_DECODE && dec_mode == M_IX
		|=> state_ff == S_EA && ea_ff == {8'h00, $past(idx_ff)})
		else $error("indexed address wrong");
	index_offset8_a: assert property (state_ff == S_OP1 && cur_mode == M_IX1
		|=> ea_ff == {8'h00, $past(idx_ff)} + {8'h00, $past(mem_rdata_in)} && ea_ff <= 16'h01FE)
		else $error("indexed 8-bit offset address wrong");
	branch_false_a: assert property (state_ff == S_OP1 && cur_mode == M_REL && !br_true
		|=> pc_ff == $past(pc_ff) ##1 mem_rd_out && mem_addr_out == $past(pc_ff, 2))
		else $error("false branch changed program flow");
	rmw_writeback_a: assert property (rmw_read_s |=> mem_wr_out && mem_addr_out == $past(ea_ff))
		else $error("read-modify-write missed its write-back");
	test_no_write_a: assert property (state_ff == S_DATA && is_rmw && cur_lo == `RMW_TEST_NEGATIVE_ZERO
		|=> !mem_wr_out [*2])
		else $error("test instruction wrote memory");
	bit_carry_a: assert property (state_ff == S_DATA && cur_mode == M_BIT_BRANCH
		|=> ccr_ff[`CCR_C] == $past(bit_val) ##1 state_ff == S_BREL)
		else $error("tested bit not copied to carry");

endmodule : cpu_addressing_decode

// File: mem_model.sv
// unified memory and i/o space model facing the cpu bus
module mem_model (
	input wire logic clk_in, // cpu clock
	input wire logic rd_in, // read strobe
	input wire logic wr_in, // write strobe
	input wire logic [15:0] addr_in, // byte address
	input wire logic [7:0] wdata_in, // write data
	output logic [7:0] rdata_out // read data, valid the cycle after a read
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] mem [0:65535];
	initial rdata_out = 8'h00;
	// answer a read one cycle later; otherwise flip the bus so stale data never looks valid
	always @(posedge clk_in) begin
		if (wr_in) begin
			mem[addr_in] <= wdata_in;
		end
		if (rd_in) begin
			rdata_out <= mem[addr_in];
		end else begin
			rdata_out <= ~rdata_out;
		end
	end
endmodule : mem_model

// File: tb_top.sv
// self-checking bench for the cpu addressing and decode block
`include "cpu_addr_defs.svh"
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_in = 1'b0;
	logic resetn_in = 1'b0;
	logic irq_pin_in = 1'b0;
	logic [7:0] mem_rdata_in, mem_wdata_out, acc_out, idx_out;
	logic [15:0] mem_addr_out, pc_out;
	logic mem_rd_out, mem_wr_out, done_out;
	logic [4:0] ccr_out;
	int fails = 0;
	int check_count = 0;
	int writes = 0;
	always #5 clk_in = ~clk_in;
	cpu_addressing_decode cpu_addressing_decode_inst (.clk_in(clk_in), .resetn_in(resetn_in),
		.mem_rdata_in(mem_rdata_in), .irq_pin_in(irq_pin_in), .mem_addr_out(mem_addr_out),
		.mem_rd_out(mem_rd_out), .mem_wr_out(mem_wr_out), .mem_wdata_out(mem_wdata_out),
		.acc_out(acc_out), .idx_out(idx_out), .pc_out(pc_out), .ccr_out(ccr_out), .done_out(done_out));
	mem_model mem_model_inst (.clk_in(clk_in), .rd_in(mem_rd_out), .wr_in(mem_wr_out),
		.addr_in(mem_addr_out), .wdata_in(mem_wdata_out), .rdata_out(mem_rdata_in));
	// count write strobes so a scenario can tell whether a write-back happened
	always @(posedge clk_in) begin
		if (mem_wr_out === 1'b1) begin
			writes <= writes + 1;
		end
	end
	task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
		check_count++;
		if (got !== exp) begin
			fails++;
			$display("wrong value %s expected %h seen %h", name, exp, got);
		end
	endtask : chk
	task automatic finish_test();
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : finish_test
	task automatic pk(input logic [15:0] a, input logic [7:0] b[$]);
		foreach (b[i]) begin
			mem_model_inst.mem[a + 16'(i)] = b[i];
		end
	endtask : pk
	// hold reset, fill memory with no-op bytes and load a program at address zero
	task automatic start(input logic [7:0] b[$]);
		@(negedge clk_in);
		resetn_in = 1'b0;
		for (int i = 0; i < 65536; i++) begin
			mem_model_inst.mem[i] = 8'h9D;
		end
		pk(16'h0000, b);
	endtask : start
	// release reset if held, then wait for n instruction completions
	task automatic step(input int n);
		int t;
		if (resetn_in === 1'b0) begin
			repeat (3) @(negedge clk_in);
			resetn_in = 1'b1;
		end
		repeat (n) begin
			t = 0;
			do begin
				@(negedge clk_in);
				t++;
			end while (done_out !== 1'b1 && t < 100);
			if (t >= 100) begin
				fails++;
				$display("wrong value done pulse expected 1 seen %b", done_out);
			end
		end
	endtask : step
	task automatic s_mul();
		start('{8'hA6, 8'hF0, 8'hAE, 8'h11, 8'h42, 8'hAE, 8'h03, 8'h4C, 8'h5A, 8'hB7, 8'h70});
		step(3);
		chk("product high", 16'h000F, {8'h00, idx_out});
		chk("product low", 16'h00F0, {8'h00, acc_out});
		step(1);
		chk("load after multiply", 16'h0003, {8'h00, idx_out});
		step(2);
		chk("accumulator increment", 16'h00F1, {8'h00, acc_out});
		chk("index decrement", 16'h0002, {8'h00, idx_out});
		step(1);
		// a store strobes in the same cycle as done, so let it land first
		@(negedge clk_in);
		chk("stored accumulator", 16'h00F1, {8'h00, mem_model_inst.mem[16'h0070]});
	endtask : s_mul
	task automatic s_modes();
		logic [7:0] exp [5] = '{8'h11, 8'h22, 8'h33, 8'h44, 8'h55};
		start('{8'hAE, 8'h80, 8'hB6, 8'h40, 8'hC6, 8'h12, 8'h34, 8'hF6, 8'hE6, 8'hFF, 8'hD6, 8'h12, 8'h00});
		pk(16'h0040, '{8'h11});
		pk(16'h1234, '{8'h22});
		pk(16'h0080, '{8'h33});
		pk(16'h017F, '{8'h44});
		pk(16'h1280, '{8'h55});
		step(1);
		for (int i = 0; i < 5; i++) begin
			step(1);
			chk("loaded operand", {8'h00, exp[i]}, {8'h00, acc_out});
		end
	endtask : s_modes
	task automatic s_rmw();
		int w;
		start('{8'h3C, 8'h50, 8'h3D, 8'h50, 8'h10, 8'h60, 8'h1F, 8'h60});
		pk(16'h0050, '{8'h7F});
		pk(16'h0060, '{8'h80});
		step(1);
		// the write-back strobe stands in the done cycle; wait for it to land
		@(negedge clk_in);
		chk("incremented byte", 16'h0080, {8'h00, mem_model_inst.mem[16'h0050]});
		w = writes;
		step(1);
		chk("test write count", 16'h0000, 16'(writes - w));
		chk("test negative flag", 16'h0001, {15'h0000, ccr_out[`CCR_N]});
		step(2);
		@(negedge clk_in);
		chk("bit set then clear", 16'h0001, {8'h00, mem_model_inst.mem[16'h0060]});
	endtask : s_rmw
	task automatic s_jump();
		start('{8'hCC, 8'h03, 8'h00});
		pk(16'h0300, '{8'hBD, 8'h80});
		pk(16'h0080, '{8'hA6, 8'h5A});
		step(3);
		chk("jump target load", 16'h005A, {8'h00, acc_out});
		chk("pc after subroutine entry", 16'h0082, pc_out);
		chk("return address", 16'h0302, {mem_model_inst.mem[16'h00FE], mem_model_inst.mem[16'h00FF]});
	endtask : s_jump
	task automatic s_branch();
		start('{8'h21, 8'h05, 8'h20, 8'h7F, 8'h9D, 8'hA6, 8'h77, 8'h2F, 8'h02, 8'hA6, 8'hEE,
			8'h2E, 8'h02, 8'hA6, 8'h33, 8'h9D, 8'h9D, 8'h2E, 8'h02, 8'hA6, 8'hEE, 8'hA6, 8'h44});
		pk(16'h0083, '{8'h20, 8'h80});
		irq_pin_in = 1'b1;
		step(4);
		chk("never, forward, backward", 16'h0077, {8'h00, acc_out});
		chk("pc after backward branch", 16'h0007, pc_out);
		step(3);
		chk("pin high taken, low not", 16'h0033, {8'h00, acc_out});
		irq_pin_in = 1'b0;
		step(4);
		chk("pin low taken", 16'h0044, {8'h00, acc_out});
	endtask : s_branch
	task automatic s_bits();
		start('{8'h06, 8'h30, 8'h03, 8'hA6, 8'hAA, 8'h9D, 8'h0F, 8'h30, 8'h05, 8'hA6, 8'hAA,
			8'h9D, 8'h9D, 8'h9D, 8'h07, 8'h30, 8'h02, 8'hA6, 8'hBB});
		pk(16'h0030, '{8'h08});
		step(1);
		chk("carry from set bit", 16'h0001, {15'h0000, ccr_out[`CCR_C]});
		step(1);
		chk("carry from clear bit", 16'h0000, {15'h0000, ccr_out[`CCR_C]});
		step(1);
		chk("carry when not taken", 16'h0001, {15'h0000, ccr_out[`CCR_C]});
		step(1);
		chk("bit branch path", 16'h00BB, {8'h00, acc_out});
	endtask : s_bits
	// run every scenario in turn
	initial begin
		s_mul();
		s_modes();
		s_rmw();
		s_jump();
		s_branch();
		s_bits();
		finish_test();
	end
	// watchdog cuts a hang short
	initial begin
		#500000;
		fails++;
		finish_test();
	end
endmodule : tb_top
